// ===== bench/mcs_cursor_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module mcs_cursor_regs_assertions
  import mcs_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic MEM_WR_DONE,
  input wire logic MEM_RD_DONE,
  input wire logic [SCALE_W-1:0] FONT_SCALE,
  input wire mcs_pos_t WR_POS,
  input wire mcs_pos_t RD_POS,
  input wire logic [DISP_W-1:0] CURSOR_W_PIX,
  input wire logic [DISP_W-1:0] CURSOR_H_PIX
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  a_dir_ro_bits: assert property (RD && ADDR == ADDR_READ_SCAN_DIR |=> RDATA[7:2] == 6'h00)
    else $error("direction upper bits not zero");
  a_wpos_xlow: assert property (WR && ADDR == ADDR_WRITE_POS_X_LOW |=> WR_POS.x[7:0] == $past(WDATA))
    else $error("write x low byte lost");
  a_wpos_xhigh: assert property (WR && ADDR == ADDR_WRITE_POS_X_HIGH |=> WR_POS.x[9:8] == $past(WDATA[1:0]))
    else $error("write x high bits lost");
  a_wpos_yhigh: assert property (WR && ADDR == ADDR_WRITE_POS_Y_HIGH |=> WR_POS.y[8] == $past(WDATA[0]))
    else $error("write y bit eight lost");
  a_write_beats_step: assert property (WR && ADDR == ADDR_WRITE_POS_X_LOW && MEM_WR_DONE |=> WR_POS.y == $past(WR_POS.y))
    else $error("auto step leaked into a host position write");
  a_rpos_xhigh: assert property (WR && ADDR == ADDR_READ_POS_X_HIGH |=> RD_POS.x[9:8] == $past(WDATA[1:0]))
    else $error("read x high bits lost");
  a_rpos_ylow: assert property (WR && ADDR == ADDR_READ_POS_Y_LOW |=> RD_POS.y[7:0] == $past(WDATA))
    else $error("read y low byte lost");
  a_width_ro_bits: assert property (RD && ADDR == ADDR_CURSOR_WIDTH |=> RDATA[7:5] == 3'h0)
    else $error("width upper bits not zero");
  a_wpos_still: assert property (!WR && !MEM_WR_DONE |=> $stable(WR_POS))
    else $error("write cursor moved without cause");
  a_rpos_still: assert property (!WR && !MEM_RD_DONE |=> $stable(RD_POS))
    else $error("read cursor moved without cause");
  // Scale must be steady one cycle back, since the product lags a cycle
  a_width_scaled: assert property (FONT_SCALE == 2'h2 && $past(FONT_SCALE) == 2'h2 |-> CURSOR_W_PIX % 7'h03 == 7'h00)
    else $error("cursor width not scaled");
  a_height_scaled: assert property (FONT_SCALE == 2'h2 && $past(FONT_SCALE) == 2'h2 |-> CURSOR_H_PIX % 7'h03 == 7'h00)
    else $error("cursor height not scaled");
endmodule // mcs_cursor_regs_assertions
bind mcs_cursor_regs mcs_cursor_regs_assertions u_chk (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .MEM_WR_DONE(MEM_WR_DONE), .MEM_RD_DONE(MEM_RD_DONE),
  .FONT_SCALE(FONT_SCALE), .WR_POS(WR_POS), .RD_POS(RD_POS), .CURSOR_W_PIX(CURSOR_W_PIX),
  .CURSOR_H_PIX(CURSOR_H_PIX));
`default_nettype wire

// ===== bench/mcs_cursor_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module mcs_cursor_regs_tb_top
  import mcs_pkg::*;
;
  logic mclk, rst, wr_s, rd_s, text_mode, show;
  logic [2:0] ev;
  logic [7:0] addr, wdata, rdata;
  logic [SCALE_W-1:0] font_scale;
  mcs_bounds_t bounds;
  mcs_pos_t wr_pos, rd_pos;
  logic [DISP_W-1:0] w_pix, h_pix;
  int fail_count, checks_done, cyc;
  logic [7:0] rst_v[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00};
  logic [7:0] msk_v[12] = '{8'hFF, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'h01, 8'hFF, 8'h03, 8'hFF, 8'h01, 8'h1F, 8'h1F};
  // From x=5,y=5, one step in each of the four scan orders
  logic [18:0] exp_v[4] = '{{10'h006, 9'h005}, {10'h004, 9'h005}, {10'h005, 9'h006}, {10'h005, 9'h004}};

  mcs_cursor_regs dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .FRAME_TICK(ev[2]), .MEM_WR_DONE(ev[0]), .MEM_RD_DONE(ev[1]), .BOUNDS(bounds), .FONT_SCALE(font_scale),
    .WR_POS(wr_pos), .RD_POS(rd_pos), .TEXT_MODE(text_mode), .CURSOR_SHOW(show), .CURSOR_W_PIX(w_pix),
    .CURSOR_H_PIX(h_pix));

  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1 chk(19'(rdata), 19'(e));
    @(posedge mclk);
  endtask
  // Gap cycle after the pulse keeps back-to-back calls single-driven
  task automatic pulse(input logic [2:0] m);
    ev <= m;
    @(posedge mclk);
    ev <= 3'h0;
    @(posedge mclk);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    rst = 1'b1;
    {wr_s, rd_s, ev, addr, wdata, font_scale} = '0;
    bounds = '{x_max: 10'h064, y_max: 9'h032};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk(19'(w_pix), 19'h00007);
    @(posedge mclk);
    for (int i = 0; i < 12; i++) rd(8'h44 + 8'(i), rst_v[i]);
    rd(8'h50, 8'h00);
    for (int i = 0; i < 12; i++) begin
      wr(8'h44 + 8'(i), 8'hFF);
      rd(8'h44 + 8'(i), msk_v[i]);
    end
    chk(wr_pos, {10'h3FF, 9'h1FF});
    chk(rd_pos, {10'h3FF, 9'h1FF});
    wr(ADDR_WRITE_CONTROL_PRIMARY, 8'hFF);
    rd(ADDR_WRITE_CONTROL_PRIMARY, 8'hEF);
    $display("Test registers done");
    font_scale <= 2'h2;
    wr(ADDR_CURSOR_WIDTH, 8'h05);
    wr(ADDR_CURSOR_HEIGHT, 8'h03);
    @(posedge mclk);
    #1 chk(19'(w_pix), 19'h0000F);
    chk(19'(h_pix), 19'h00009);
    @(posedge mclk);
    $display("Test scale done");
    for (int k = 0; k < 2; k++) begin
      for (int d = 0; d < 4; d++) begin
        wr(k ? ADDR_READ_SCAN_DIR : ADDR_WRITE_CONTROL_PRIMARY, k ? 8'(d) : 8'(d << 2));
        for (int j = 0; j < 4; j++) wr((k ? 8'h4A : 8'h46) + 8'(j), j[0] ? 8'h00 : 8'h05);
        pulse(k ? 3'h2 : 3'h1);
        #1 chk(k ? rd_pos : wr_pos, exp_v[d]);
        @(posedge mclk);
      end
    end
    wr(ADDR_WRITE_CONTROL_PRIMARY, 8'h03);
    pulse(3'h3);
    #1 chk(wr_pos, {10'h005, 9'h004});
    chk(rd_pos, {10'h005, 9'h004});
    @(posedge mclk);
    // Host write and memory write in one cycle: the host position stands whole
    wr(ADDR_WRITE_CONTROL_PRIMARY, 8'h0C);
    ev <= 3'h1;
    addr <= ADDR_WRITE_POS_X_LOW;
    wdata <= 8'h20;
    wr_s <= 1'b1;
    @(posedge mclk);
    ev <= 3'h0;
    wr_s <= 1'b0;
    @(posedge mclk);
    #1 chk(wr_pos, {10'h020, 9'h004});
    @(posedge mclk);
    // Text mode runs left to right whatever the direction field says
    wr(ADDR_WRITE_CONTROL_PRIMARY, 8'h8C);
    pulse(3'h1);
    #1 chk(wr_pos, {10'h021, 9'h004});
    chk(19'(text_mode), 19'h00001);
    @(posedge mclk);
    wr(ADDR_WRITE_CONTROL_PRIMARY, 8'h00);
    wr(ADDR_WRITE_POS_X_LOW, 8'h64);
    pulse(3'h1);
    #1 chk(wr_pos, {10'h000, 9'h005});
    chk(19'(text_mode), 19'h00000);
    @(posedge mclk);
    $display("Test stepping done");
    wr(ADDR_BLINK_PERIOD, 8'h01);
    wr(ADDR_WRITE_CONTROL_PRIMARY, 8'h60);
    pulse(3'h4);
    #1 chk(19'(show), 19'h00001);
    pulse(3'h4);
    @(posedge mclk);
    #1 chk(19'(show), 19'h00000);
    pulse(3'h4);
    pulse(3'h4);
    @(posedge mclk);
    #1 chk(19'(show), 19'h00001);
    wr(ADDR_WRITE_CONTROL_PRIMARY, 8'h00);
    @(posedge mclk);
    #1 chk(19'(show), 19'h00000);
    $display("Test blink done");
    stop_test();
  end
endmodule // mcs_cursor_regs_tb_top
`default_nettype wire

// ===== hw/mcs_cursor_regs.sv
// What this block does
// [R1] The blink period counts display frames, a value N giving N plus one frames per interval.
// [R2] In graphic mode the read cursor steps by a two-bit direction in one of four scan orders.
// [R3] The write cursor horizontal position is ten bits, low byte in one register, two top bits in the next.
// [R4] The write cursor vertical position is nine bits, low byte in one register, bit eight in the next.
// [R5] The read cursor horizontal position is ten bits split the same way across two registers.
// [R6] The read cursor vertical position is nine bits split the same way across two registers.
// [R7] The cursor width is five bits of pixels and resets to seven.
// [R8] The cursor height is five bits of pixels and resets to zero.
// [R9] Enlarged text scales the shown cursor width and height by the font factor.
// [R10] Each memory write advances the write cursor unless its hold bit is set or a host write to its position bytes falls in that cycle.
// [R11] Each memory read advances the read cursor unless its hold bit is set or a host write to its position bytes falls in that cycle.
// [R12] In graphic mode the write cursor steps by its own two-bit direction with the same four orders.
// [R13] The write cursor is shown only while visible is set, and blinks while blink enable is set.
// [R14] While blinking, the cursor toggles between shown and hidden each time the interval elapses.
// [R15] A position written by software is where the next access of that kind takes place.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module mcs_cursor_regs
  import mcs_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic FRAME_TICK,
  input wire logic MEM_WR_DONE,
  input wire logic MEM_RD_DONE,
  input wire mcs_bounds_t BOUNDS,
  input wire logic [SCALE_W-1:0] FONT_SCALE,
  output mcs_pos_t WR_POS,
  output mcs_pos_t RD_POS,
  output logic TEXT_MODE,
  output logic CURSOR_SHOW,
  output logic [DISP_W-1:0] CURSOR_W_PIX,
  output logic [DISP_W-1:0] CURSOR_H_PIX
);

  logic [7:0] ctl_q, ctl_d;
  logic [7:0] blink_period_q, blink_period_d;
  logic [1:0] rdir_q, rdir_d;
  mcs_pos_t wpos_q, wpos_d;
  mcs_pos_t rpos_q, rpos_d;
  logic [SIZE_W-1:0] cw_q, cw_d;
  logic [SIZE_W-1:0] ch_q, ch_d;
  logic [7:0] frames_q, frames_d;
  mcs_blink_t blink_q, blink_d;
  logic [7:0] rdata_q, rdata_d;
  logic show_q, show_d;
  logic [DISP_W-1:0] cwp_q, cwp_d, chp_q, chp_d;
  logic wr_pos_hit, rd_pos_hit, wr_step, rd_step;
  logic [1:0] wdir_eff, rdir_eff;

  // Forward axis steps wrap to the origin past their limit
  function automatic logic [X_W-1:0] x_fwd(input logic [X_W-1:0] v, input logic [X_W-1:0] lim);
    return (v >= lim) ? RST_X : X_W'(v + 1'b1);
  endfunction

  function automatic logic [Y_W-1:0] y_fwd(input logic [Y_W-1:0] v, input logic [Y_W-1:0] lim);
    return (v >= lim) ? RST_Y : Y_W'(v + 1'b1);
  endfunction

  // Next position in scan order, wrapping at the active bounds
  function automatic mcs_pos_t step(input mcs_pos_t p, input logic [1:0] dir, input mcs_bounds_t b);
    mcs_pos_t n;
    n = p;
    case (mcs_dir_t'(dir))
      DIR_LR_TD: begin
        n.x = x_fwd(p.x, b.x_max);
        if (p.x >= b.x_max) begin
          n.y = y_fwd(p.y, b.y_max);
        end
      end
      DIR_RL_TD: begin
        if (p.x == RST_X) begin
          n.x = b.x_max;
          n.y = y_fwd(p.y, b.y_max);
        end else begin
          n.x = X_W'(p.x - 1'b1);
        end
      end
      DIR_TD_LR: begin
        n.y = y_fwd(p.y, b.y_max);
        if (p.y >= b.y_max) begin
          n.x = x_fwd(p.x, b.x_max);
        end
      end
      default: begin
        if (p.y == RST_Y) begin
          n.y = b.y_max;
          n.x = x_fwd(p.x, b.x_max);
        end else begin
          n.y = Y_W'(p.y - 1'b1);
        end
      end
    endcase
    return n;
  endfunction

  // Size scaled by factor 1..4
  function automatic logic [DISP_W-1:0] scale(input logic [SIZE_W-1:0] s, input logic [SCALE_W-1:0] f);
    return DISP_W'(s * ({1'b0, f} + 3'h1));
  endfunction

  // Position bytes sit at consecutive addresses, so a range test finds them
  function automatic logic in_span(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Host write to any byte of a cursor replaces its auto step in that cycle
  assign wr_pos_hit = WR && in_span(ADDR, ADDR_WRITE_POS_X_LOW, ADDR_WRITE_POS_Y_HIGH); // [R15]
  assign rd_pos_hit = WR && in_span(ADDR, ADDR_READ_POS_X_LOW, ADDR_READ_POS_Y_HIGH); // [R15]
  // Auto steps, each gated by its hold bit
  assign wr_step = MEM_WR_DONE && !ctl_q[CTL_WR_HOLD_BIT]; // [R10]
  assign rd_step = MEM_RD_DONE && !ctl_q[CTL_RD_HOLD_BIT]; // [R11]
  // Text mode ignores both direction fields and always runs left to right
  assign wdir_eff = ctl_q[CTL_TEXT_BIT] ? 2'(DIR_LR_TD) : ctl_q[CTL_WDIR_LSB +: 2]; // [R12]
  assign rdir_eff = ctl_q[CTL_TEXT_BIT] ? 2'(DIR_LR_TD) : rdir_q; // [R2]

  // Settings; the control byte keeps its unused bit at zero
  always_comb begin
    ctl_d = ctl_q;
    blink_period_d = blink_period_q;
    rdir_d = rdir_q;
    cw_d = cw_q;
    ch_d = ch_q;
    if (WR) begin
      case (ADDR)
        ADDR_WRITE_CONTROL_PRIMARY: ctl_d = WDATA & CTL_RW_MASK;
        ADDR_BLINK_PERIOD: blink_period_d = WDATA; // [R1]
        ADDR_READ_SCAN_DIR: rdir_d = WDATA[1:0]; // [R2]
        ADDR_CURSOR_WIDTH: cw_d = WDATA[SIZE_W-1:0]; // [R7]
        ADDR_CURSOR_HEIGHT: ch_d = WDATA[SIZE_W-1:0]; // [R8]
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctl_q <= '0;
      blink_period_q <= RST_BLINK_PERIOD;
      rdir_q <= RST_DIR;
      cw_q <= RST_CURSOR_WIDTH; // [R7]
      ch_q <= RST_CURSOR_HEIGHT; // [R8]
    end else begin
      ctl_q <= ctl_d;
      blink_period_q <= blink_period_d;
      rdir_q <= rdir_d;
      cw_q <= cw_d;
      ch_q <= ch_d;
    end
  end

  // A step that meets a host write is dropped, not deferred
  always_comb begin
    wpos_d = wpos_q;
    if (wr_pos_hit) begin
      case (ADDR)
        ADDR_WRITE_POS_X_LOW: wpos_d.x[7:0] = WDATA; // [R3] [R15]
        ADDR_WRITE_POS_X_HIGH: wpos_d.x[9:8] = WDATA[1:0]; // [R3]
        ADDR_WRITE_POS_Y_LOW: wpos_d.y[7:0] = WDATA; // [R4]
        ADDR_WRITE_POS_Y_HIGH: wpos_d.y[8] = WDATA[0]; // [R4]
        default: ;
      endcase
    end else if (wr_step) begin // [R10]
      wpos_d = step(wpos_q, wdir_eff, BOUNDS); // [R12]
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wpos_q <= '{x: RST_X, y: RST_Y};
    end else begin
      wpos_q <= wpos_d;
    end
  end

  // Same priority for the read cursor
  always_comb begin
    rpos_d = rpos_q;
    if (rd_pos_hit) begin
      case (ADDR)
        ADDR_READ_POS_X_LOW: rpos_d.x[7:0] = WDATA; // [R5] [R15]
        ADDR_READ_POS_X_HIGH: rpos_d.x[9:8] = WDATA[1:0]; // [R5]
        ADDR_READ_POS_Y_LOW: rpos_d.y[7:0] = WDATA; // [R6]
        ADDR_READ_POS_Y_HIGH: rpos_d.y[8] = WDATA[0]; // [R6]
        default: ;
      endcase
    end else if (rd_step) begin // [R11]
      rpos_d = step(rpos_q, rdir_eff, BOUNDS); // [R2]
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rpos_q <= '{x: RST_X, y: RST_Y};
    end else begin
      rpos_q <= rpos_d;
    end
  end

  // Frames are counted only while blinking is on
  always_comb begin
    frames_d = frames_q;
    blink_d = blink_q;
    if (!ctl_q[CTL_BLINK_BIT]) begin
      frames_d = '0;
      blink_d = BLINK_SHOWN;
    end else if (FRAME_TICK) begin
      // Counter reaching the period means N+1 frames have passed
      if (frames_q >= blink_period_q) begin // [R1]
        frames_d = '0;
        blink_d = (blink_q == BLINK_SHOWN) ? BLINK_HIDDEN : BLINK_SHOWN; // [R14]
      end else begin
        frames_d = 8'(frames_q + 1'b1);
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      frames_q <= '0;
      blink_q <= BLINK_SHOWN;
    end else begin
      frames_q <= frames_d;
      blink_q <= blink_d;
    end
  end

  always_comb begin
    show_d = ctl_q[CTL_VISIBLE_BIT]; // [R13]
    if (ctl_q[CTL_BLINK_BIT] && blink_q == BLINK_HIDDEN) begin // [R13]
      show_d = 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      show_q <= 1'b0;
    end else begin
      show_q <= show_d;
    end
  end

  // Shown size lags a scale change by one cycle
  always_comb begin
    cwp_d = scale(cw_q, FONT_SCALE); // [R9]
    chp_d = scale(ch_q, FONT_SCALE); // [R9]
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cwp_q <= '0;
      chp_q <= '0;
    end else begin
      cwp_q <= cwp_d;
      chp_q <= chp_d;
    end
  end

  // Unmapped addresses and unused bits read as zero
  always_comb begin
    rdata_d = 8'h00;
    if (RD) begin
      case (ADDR)
        ADDR_WRITE_CONTROL_PRIMARY: rdata_d = ctl_q;
        ADDR_BLINK_PERIOD: rdata_d = blink_period_q;
        ADDR_READ_SCAN_DIR: rdata_d = {6'h00, rdir_q};
        ADDR_WRITE_POS_X_LOW: rdata_d = wpos_q.x[7:0];
        ADDR_WRITE_POS_X_HIGH: rdata_d = {6'h00, wpos_q.x[9:8]};
        ADDR_WRITE_POS_Y_LOW: rdata_d = wpos_q.y[7:0];
        ADDR_WRITE_POS_Y_HIGH: rdata_d = {7'h00, wpos_q.y[8]};
        ADDR_READ_POS_X_LOW: rdata_d = rpos_q.x[7:0];
        ADDR_READ_POS_X_HIGH: rdata_d = {6'h00, rpos_q.x[9:8]};
        ADDR_READ_POS_Y_LOW: rdata_d = rpos_q.y[7:0];
        ADDR_READ_POS_Y_HIGH: rdata_d = {7'h00, rpos_q.y[8]};
        ADDR_CURSOR_WIDTH: rdata_d = {3'h0, cw_q};
        ADDR_CURSOR_HEIGHT: rdata_d = {3'h0, ch_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;
  assign WR_POS = wpos_q;
  assign RD_POS = rpos_q;
  assign TEXT_MODE = ctl_q[CTL_TEXT_BIT];
  assign CURSOR_SHOW = show_q;
  assign CURSOR_W_PIX = cwp_q;
  assign CURSOR_H_PIX = chp_q;

endmodule // mcs_cursor_regs
`default_nettype wire

// ===== hw/mcs_pkg.sv
package mcs_pkg;

  localparam logic [7:0] ADDR_BLINK_PERIOD = 8'h44;
  localparam logic [7:0] ADDR_READ_SCAN_DIR = 8'h45;
  localparam logic [7:0] ADDR_WRITE_POS_X_LOW = 8'h46;
  localparam logic [7:0] ADDR_WRITE_POS_X_HIGH = 8'h47;
  localparam logic [7:0] ADDR_WRITE_POS_Y_LOW = 8'h48;
  localparam logic [7:0] ADDR_WRITE_POS_Y_HIGH = 8'h49;
  localparam logic [7:0] ADDR_READ_POS_X_LOW = 8'h4A;
  localparam logic [7:0] ADDR_READ_POS_X_HIGH = 8'h4B;
  localparam logic [7:0] ADDR_READ_POS_Y_LOW = 8'h4C;
  localparam logic [7:0] ADDR_READ_POS_Y_HIGH = 8'h4D;
  localparam logic [7:0] ADDR_CURSOR_WIDTH = 8'h4E;
  localparam logic [7:0] ADDR_CURSOR_HEIGHT = 8'h4F;
  localparam logic [7:0] ADDR_WRITE_CONTROL_PRIMARY = 8'h40;

  localparam int X_W = 10;
  localparam int Y_W = 9;
  localparam int SIZE_W = 5;
  localparam int SCALE_W = 2;
  localparam int DISP_W = SIZE_W + SCALE_W;

  localparam logic [7:0] RST_BLINK_PERIOD = 8'h00;
  localparam logic [1:0] RST_DIR = 2'h0;
  localparam logic [SIZE_W-1:0] RST_CURSOR_WIDTH = 5'h07;
  localparam logic [SIZE_W-1:0] RST_CURSOR_HEIGHT = 5'h00;
  localparam logic [X_W-1:0] RST_X = 10'h000;
  localparam logic [Y_W-1:0] RST_Y = 9'h000;

  // Control byte fields
  localparam int CTL_TEXT_BIT = 7;
  localparam int CTL_VISIBLE_BIT = 6;
  localparam int CTL_BLINK_BIT = 5;
  localparam int CTL_WDIR_LSB = 2;
  localparam int CTL_WR_HOLD_BIT = 1;
  localparam int CTL_RD_HOLD_BIT = 0;
  localparam logic [7:0] CTL_RW_MASK = 8'hEF;

  typedef enum logic [1:0] {
    DIR_LR_TD = 2'h0,
    DIR_RL_TD = 2'h1,
    DIR_TD_LR = 2'h2,
    DIR_DT_LR = 2'h3
  } mcs_dir_t;

  typedef struct packed {
    logic [X_W-1:0] x;
    logic [Y_W-1:0] y;
  } mcs_pos_t;

  typedef struct packed {
    logic [X_W-1:0] x_max;
    logic [Y_W-1:0] y_max;
  } mcs_bounds_t;

  typedef enum logic {
    BLINK_SHOWN,
    BLINK_HIDDEN
  } mcs_blink_t;

endpackage : mcs_pkg
